// ===== rtl/ppdr_port.sv
// port-level deadlock avoidance, retransmit store and time-outs
// What this block does
// - requests needing responses never go out at the top priority
// - responses leave at least one level above their request, or at the top level for a top-level request
// - switch accepts priority N if no older N-or-higher packet waits, else when space fits
// - one input buffer reserved per priority level above the lowest (levels 1 to 3), shared above it
// - after a retry of priority N, prefer a waiting higher packet
// - end point accepts when level's buffer space fits; only refuse for space
// - accept decision ignores whether outbound requests are blocked
// - transmit queue never fills completely with requests
// - four input buffers with reservation, higher-priority selection
// - with USE_PROMOTE set, retried responses are promoted step by step
// - crc passes unchanged except maintenance packets in a switch (IS_SWITCH), which are recomputed
// - link and response time-out counters flag missing answers
// - link time-out runs from send to acknowledgment
// - link time-out handled like an unexpected acknowledgment
// - two-response operations wait for both responses on any link
// - every packet acknowledged except during inbound error stop; copy kept until accepted or unrecoverable
// - corrupted inbound packet answered with not-accepted
// - after link-request exchange resume with corrupted or higher packet
// - every corrupted packet resent up to a programmable limit
// - time-out defaults are long to avoid false expiry
// - promotion goes only as far as needed
// - error recovery stops sending, resets timers, sends link-request
// - on link-response back up to first unaccepted packet and resume
`timescale 1ns/1ps
`include "ppdr_defs.svh"
module ppdr_port #(
  parameter bit IS_SWITCH    = 1'b0,
  parameter bit USE_PROMOTE  = 1'b0,
  parameter int DW           = 32,
  parameter int FIFO_DEPTH   = 16
) (
  input  wire logic               clock,        // core clock
  input  wire logic               rst,          // sync reset
  input  wire logic [23:0]        link_to_cfg,  // link time-out cycles
  input  wire logic [23:0]        resp_to_cfg,  // response time-out cycles
  input  wire logic [7:0]         retry_limit,  // resend limit
  input  wire logic               rx_valid,     // inbound packet offered
  input  wire ppdr_pkg::ppdr_prio_t rx_prio,    // its priority
  input  wire ppdr_pkg::ppdr_tag_t  rx_tag,     // its sequence tag
  input  wire logic               rx_crc_bad,   // corrupted
  input  wire logic               rx_is_maint,  // maintenance packet
  input  wire logic [DW-1:0]      rx_data,      // packet word
  input  wire logic               in_release,   // one input buffer freed
  input  wire ppdr_pkg::ppdr_prio_t in_rel_prio,// priority of freed buffer
  output logic                    rx_ack_valid, // acknowledgment pulse
  output ppdr_pkg::ppdr_ack_e     rx_ack_kind,  // accept/retry/not-accepted
  output ppdr_pkg::ppdr_tag_t     rx_ack_tag,   // acknowledged tag
  output logic                    rx_crc_redo,  // crc must be recomputed
  output logic [DW-1:0]           fwd_data,     // forwarded word
  output logic                    fwd_valid,    // forwarded word valid
  input  wire logic               fwd_ready,    // downstream ready
  input  wire logic               tq_valid,     // new packet to send
  input  wire logic               tq_is_resp,   // it is a response
  input  wire logic               tq_needs_resp,// request wanting a response
  input  wire logic               tq_two_resp,  // expects two responses
  input  wire ppdr_pkg::ppdr_prio_t tq_req_prio,// priority (or request's)
  output logic                    tq_ready,     // slot available
  input  wire logic               resp_rx,      // response arrived, any link
  input  wire logic               tx_ack_valid, // ack from partner
  input  wire ppdr_pkg::ppdr_ack_e tx_ack_kind, // its kind
  input  wire ppdr_pkg::ppdr_tag_t tx_ack_tag,  // its tag
  input  wire logic               lresp_valid,  // link-response arrived
  input  wire ppdr_pkg::ppdr_tag_t lresp_tag,   // partner's expected tag
  output logic                    tx_send,      // send pulse
  output logic [2:0]              tx_slot,      // slot sent
  output ppdr_pkg::ppdr_prio_t    tx_prio,      // priority sent
  output ppdr_pkg::ppdr_tag_t     tx_tag,       // tag sent
  output logic                    lreq_send,    // link-request pulse
  output logic                    out_err_stop, // output error-stopped
  output logic                    link_timeout, // link time-out pulse
  output logic                    resp_timeout, // response time-out pulse
  output logic                    pkt_unrecov   // packet dropped as unrecoverable
);
  import ppdr_pkg::*;
  localparam int NS = `PPDR_NSLOT;
  // ---- inbound: acceptance and input buffer accounting
  logic [2:0] in_cnt_r [4];
  logic [2:0] in_total_r;
  logic       in_err_r;
  logic       fi_ready;
  wire [2:0] higher_held = in_cnt_r[3] + (rx_prio <= 2'h2 ? in_cnt_r[2] : 3'h0)
                         + (rx_prio <= 2'h1 ? in_cnt_r[1] : 3'h0) + (rx_prio == 2'h0 ? in_cnt_r[0] : 3'h0);
  // reserved buffers of levels above rx_prio still unused
  wire [2:0] resv_above = ((rx_prio < 2'h3 && in_cnt_r[3] == 3'h0) ? 3'h1 : 3'h0)
                        + ((rx_prio < 2'h2 && in_cnt_r[2] == 3'h0) ? 3'h1 : 3'h0)
                        + ((rx_prio < 2'h1 && in_cnt_r[1] == 3'h0) ? 3'h1 : 3'h0);
  wire space_ok    = (in_total_r + resv_above) < 3'(`PPDR_IN_BUFS);
  wire sw_accept   = (higher_held == 3'h0) || space_ok;
  // acceptance looks only at input space, never at outbound congestion
  wire accept_ok   = (IS_SWITCH ? sw_accept : space_ok) && fi_ready;
  wire rx_take     = rx_valid && !in_err_r && !rx_crc_bad && accept_ok;
  // no link-request input is modelled, so only reset lifts the inbound stop
  wire lreq_in_seen = 1'b0;
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_ack_valid <= 1'b0;
      rx_ack_kind  <= PPDR_ACK_NONE;
      rx_ack_tag   <= '0;
      rx_crc_redo  <= 1'b0;
      in_err_r     <= 1'b0;
    end else begin
      rx_ack_valid <= rx_valid && !in_err_r;
      rx_ack_kind  <= rx_crc_bad ? PPDR_ACK_NOT_ACC : (accept_ok ? PPDR_ACK_ACCEPT : PPDR_ACK_RETRY);
      rx_ack_tag   <= rx_tag;
      rx_crc_redo  <= rx_take && rx_is_maint && IS_SWITCH;
      // inbound error stop holds off packets; lreq_in_seen is tied low, so only reset ends it
      if (rx_valid && rx_crc_bad) in_err_r <= 1'b1;
      else if (lreq_in_seen) in_err_r <= 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) in_cnt_r[i] <= '0;
      in_total_r <= '0;
    end else begin
      for (int i = 0; i < 4; i++)
        in_cnt_r[i] <= in_cnt_r[i] + 3'((rx_take && rx_prio == 2'(i)) ? 1 : 0)
                     - 3'((in_release && in_rel_prio == 2'(i) && in_cnt_r[i] != 3'h0) ? 1 : 0);
      in_total_r <= in_total_r + 3'(rx_take) - 3'(in_release && in_cnt_r[in_rel_prio] != 3'h0);
    end
  end
  ppdr_fifo #(.W(DW), .D(FIFO_DEPTH)) u_fifo (
    .clock    (clock),
    .rst      (rst),
    .in_data  (rx_data),
    .in_valid (rx_take),
    .in_ready (fi_ready),
    .out_data (fwd_data),
    .out_valid(fwd_valid),
    .out_ready(fwd_ready)
  );
  // ---- outbound: retransmit store of NS slots
  logic [NS-1:0] v_r, sent_r, resp_r;
  ppdr_prio_t    pr_r  [NS];
  ppdr_tag_t     tg_r  [NS];
  logic [23:0]   lt_r  [NS];
  logic [7:0]    rc_r  [NS];
  ppdr_tag_t     next_tag_r;
  ppdr_prio_t    retry_floor_r;
  logic          retry_pend_r;
  logic          lreq_pend_r;
  logic [3:0]    req_cnt;
  always_comb begin
    req_cnt = '0;
    for (int i = 0; i < NS; i++) req_cnt = req_cnt + 4'(v_r[i] && !resp_r[i]);
  end
  // requests may not take the last slots, keeping room for responses
  wire room_any = ~&v_r;
  wire room_req = (req_cnt < 4'(NS - `PPDR_RESP_REQ_TX));
  assign tq_ready = room_any && (tq_is_resp || room_req) && !out_err_stop;
  wire ppdr_prio_t req_p = (tq_req_prio > `PPDR_REQ_PRIO_MAX) ? `PPDR_REQ_PRIO_MAX : tq_req_prio;
  wire ppdr_prio_t rsp_p = (tq_req_prio == `PPDR_PRIO_MAX) ? `PPDR_PRIO_MAX : tq_req_prio + 2'h1;
  wire ppdr_prio_t new_p = tq_is_resp ? rsp_p : (tq_needs_resp ? req_p : tq_req_prio);
  logic [2:0] free_i;
  always_comb begin
    free_i = '0;
    for (int i = NS - 1; i >= 0; i--) if (!v_r[i]) free_i = 3'(i);
  end
  // pick the highest waiting priority; after a retry, one above the floor while any such packet waits
  logic [2:0] sel_i;
  logic       sel_ok;
  always_comb begin
    sel_i  = '0;
    sel_ok = 1'b0;
    for (int p = 0; p < 4; p++)
      for (int i = NS - 1; i >= 0; i--)
        if (v_r[i] && !sent_r[i] && pr_r[i] == 2'(p)) begin
          sel_i  = 3'(i);
          sel_ok = 1'b1;
        end
  end
  wire above_floor = !retry_pend_r || pr_r[sel_i] > retry_floor_r;
  logic any_above;
  always_comb begin
    any_above = 1'b0;
    for (int i = 0; i < NS; i++) if (v_r[i] && !sent_r[i] && pr_r[i] > retry_floor_r) any_above = 1'b1;
  end
  wire do_send = sel_ok && !out_err_stop && (above_floor || !any_above);
  logic [2:0] ack_i;
  logic       ack_hit;
  always_comb begin
    ack_i   = '0;
    ack_hit = 1'b0;
    for (int i = 0; i < NS; i++) if (v_r[i] && sent_r[i] && tg_r[i] == tx_ack_tag) begin
      ack_i   = 3'(i);
      ack_hit = 1'b1;
    end
  end
  logic [NS-1:0] lt_exp;
  always_comb begin
    for (int i = 0; i < NS; i++) lt_exp[i] = v_r[i] && sent_r[i] && lt_r[i] >= link_to_cfg;
  end
  wire unexpected = tx_ack_valid && (!ack_hit || tx_ack_kind == PPDR_ACK_NOT_ACC);
  wire lto_any    = |lt_exp && !out_err_stop;
  wire enter_err  = (unexpected || lto_any) && !out_err_stop;
  always_ff @(posedge clock) begin
    if (rst) begin
      v_r <= '0;
      sent_r <= '0;
      resp_r <= '0;
      for (int i = 0; i < NS; i++) begin
        pr_r[i] <= '0;
        tg_r[i] <= '0;
        lt_r[i] <= '0;
        rc_r[i] <= '0;
      end
      next_tag_r <= '0;
      retry_pend_r <= 1'b0;
      retry_floor_r <= '0;
      out_err_stop <= 1'b0;
      lreq_pend_r <= 1'b0;
      lreq_send <= 1'b0;
      link_timeout <= 1'b0;
      pkt_unrecov <= 1'b0;
      tx_send <= 1'b0;
      tx_slot <= '0;
      tx_prio <= '0;
      tx_tag <= '0;
    end else begin
      tx_send <= do_send;
      lreq_send <= enter_err;
      link_timeout <= lto_any;
      pkt_unrecov <= 1'b0;
      for (int i = 0; i < NS; i++)
        if (v_r[i] && sent_r[i]) lt_r[i] <= enter_err ? 24'h0 : lt_r[i] + 24'h1;
      if (do_send) begin
        sent_r[sel_i] <= 1'b1;
        tg_r[sel_i] <= next_tag_r;
        lt_r[sel_i] <= '0;
        next_tag_r <= next_tag_r + 6'h1;
        tx_slot <= sel_i;
        tx_prio <= pr_r[sel_i];
        tx_tag <= next_tag_r;
        retry_pend_r <= 1'b0;
      end
      if (tq_valid && tq_ready) begin
        v_r[free_i] <= 1'b1;
        sent_r[free_i] <= 1'b0;
        resp_r[free_i] <= tq_is_resp;
        pr_r[free_i] <= new_p;
        rc_r[free_i] <= '0;
      end
      if (tx_ack_valid && ack_hit && !out_err_stop) begin
        if (tx_ack_kind == PPDR_ACK_ACCEPT) v_r[ack_i] <= 1'b0;
        else if (tx_ack_kind == PPDR_ACK_RETRY) begin
          sent_r[ack_i] <= 1'b0;
          retry_pend_r <= 1'b1;
          retry_floor_r <= pr_r[ack_i];
          // step up one level per retry, only while retries keep coming
          if (USE_PROMOTE && resp_r[ack_i] && pr_r[ack_i] != `PPDR_PRIO_MAX)
            pr_r[ack_i] <= pr_r[ack_i] + 2'h1;
        end
      end
      if (enter_err) begin
        out_err_stop <= 1'b1;
        lreq_pend_r <= 1'b1;
      end
      if (lresp_valid && lreq_pend_r) begin
        out_err_stop <= 1'b0;
        lreq_pend_r <= 1'b0;
        next_tag_r <= lresp_tag;
        for (int i = 0; i < NS; i++)
          if (v_r[i] && sent_r[i]) begin
            if (tg_r[i] - lresp_tag >= 6'(NS)) v_r[i] <= 1'b0;
            else if (rc_r[i] >= retry_limit) begin
              v_r[i] <= 1'b0;
              pkt_unrecov <= 1'b1;
            end else begin
              sent_r[i] <= 1'b0;
              rc_r[i] <= rc_r[i] + 8'h1;
            end
          end
      end
    end
  end
  // ---- response time-out, counting both responses of a two-response op
  logic [23:0] rt_r;
  logic [1:0]  rwait_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      rt_r <= '0;
      rwait_r <= '0;
      resp_timeout <= 1'b0;
    end else begin
      resp_timeout <= 1'b0;
      if (tq_valid && tq_ready && tq_needs_resp) begin
        rwait_r <= tq_two_resp ? 2'h2 : 2'h1;
        rt_r <= '0;
      end else if (rwait_r != 2'h0) begin
        if (resp_rx) rwait_r <= rwait_r - 2'h1;
        if (rt_r >= resp_to_cfg) begin
          resp_timeout <= 1'b1;
          rwait_r <= '0;
        end else rt_r <= rt_r + 24'h1;
      end
    end
  end
endmodule : ppdr_port

// ===== rtl/ppdr_defs.svh
// constants for the port priority, deadlock and retransmit block
`ifndef PPDR_DEFS_SVH
`define PPDR_DEFS_SVH
`define PPDR_PRIO_W        2
`define PPDR_PRIO_MAX      2'h3
`define PPDR_REQ_PRIO_MAX  2'h2
`define PPDR_TAG_W         6
`define PPDR_NSLOT         8
`define PPDR_SLOT_W        3
`define PPDR_CNT_W         24
`define PPDR_LINK_TO_DEF   24'h0003E8
`define PPDR_RESP_TO_DEF   24'h0186A0
`define PPDR_RETRY_DEF     8'h07
`define PPDR_IN_BUFS       4
`define PPDR_RESP_REQ_TX   2
`endif

// ===== rtl/ppdr_pkg.sv
// types for the port priority, deadlock and retransmit block
package ppdr_pkg;
  typedef logic [1:0] ppdr_prio_t;
  typedef logic [5:0] ppdr_tag_t;
  typedef enum logic [2:0] {PPDR_ACK_ACCEPT, PPDR_ACK_RETRY, PPDR_ACK_NOT_ACC, PPDR_ACK_NONE} ppdr_ack_e;
endpackage : ppdr_pkg

// ===== rtl/ppdr_fifo.sv
// valid/ready fifo built from flip-flops
`timescale 1ns/1ps
module ppdr_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clock,   // core clock
  input  wire logic         rst,     // sync reset
  input  wire logic [W-1:0] in_data, // fill data
  input  wire logic         in_valid,// fill valid
  output logic              in_ready,// not full
  output logic [W-1:0]      out_data,// head word
  output logic              out_valid,// not empty
  input  wire logic         out_ready // drain
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0]   cnt_r;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  always_ff @(posedge clock) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      if (pop) rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clock) begin
    if (push) mem_r[wp_r] <= in_data;
  end
endmodule : ppdr_fifo

// ===== tb/ppdr_port_sva.sv
// checker bound to the port priority and retransmit block
`timescale 1ns/1ps
module ppdr_port_sva (
  input wire logic                clock,        // clock
  input wire logic                rst,          // reset
  input wire logic [23:0]         link_to_cfg,  // limit
  input wire logic                rx_valid,     // rx
  input wire ppdr_pkg::ppdr_tag_t rx_tag,       // rx tag
  input wire logic                rx_crc_bad,   // bad
  input wire logic                rx_is_maint,  // maint
  input wire logic                rx_ack_valid, // ack
  input wire ppdr_pkg::ppdr_ack_e rx_ack_kind,  // kind
  input wire ppdr_pkg::ppdr_tag_t rx_ack_tag,   // tag
  input wire logic                rx_crc_redo,  // redo
  input wire logic                tx_ack_valid, // ack in
  input wire ppdr_pkg::ppdr_ack_e tx_ack_kind,  // kind in
  input wire logic                lresp_valid,  // lresp
  input wire logic                tx_send,      // send
  input wire logic                lreq_send,    // lreq
  input wire logic                out_err_stop, // stop
  input wire logic                link_timeout  // expiry
);
  import ppdr_pkg::*;
  logic        in_stop_r; // inbound stop clears only on reset
  logic [23:0] age_r;     // saturating age since reset
  always_ff @(posedge clock) begin
    in_stop_r <= !rst && (in_stop_r || (rx_valid && rx_crc_bad));
    age_r     <= rst ? 24'h000000 : age_r + {23'h000000, ~&age_r};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_nack;
    tx_ack_valid && tx_ack_kind == PPDR_ACK_NOT_ACC && !out_err_stop;
  endsequence
  sequence s_stop;
    lreq_send && out_err_stop;
  endsequence
  AST_ACK_EVERY: assert property (rx_valid && !in_stop_r |=> rx_ack_valid && rx_ack_tag == $past(rx_tag))
    else $error("inbound packet not acknowledged");
  AST_BAD_NACK: assert property (rx_valid && rx_crc_bad && !in_stop_r |=> rx_ack_kind == PPDR_ACK_NOT_ACC)
    else $error("corrupted packet not refused");
  AST_MAINT_CRC: assert property (rx_crc_redo |-> $past(rx_valid) && $past(rx_is_maint))
    else $error("crc redone for non-maintenance packet");
  AST_NACK_STOP: assert property (s_nack |=> s_stop)
    else $error("no link-request after refusal");
  AST_TO_STOP: assert property (link_timeout |-> s_stop)
    else $error("no link-request after time-out");
  AST_STOP_QUIET: assert property (out_err_stop && $past(out_err_stop) |-> !tx_send)
    else $error("packet sent while stopped");
  AST_STOP_EXIT: assert property ($fell(out_err_stop) && !$past(rst) |-> $past(lresp_valid))
    else $error("stop left without link-response");
  AST_TO_MIN: assert property (link_timeout |-> age_r >= link_to_cfg)
    else $error("link time-out too early");
endmodule : ppdr_port_sva
bind ppdr_port ppdr_port_sva ppdr_port_sva_inst (.clock(clock), .rst(rst), .link_to_cfg(link_to_cfg),
  .rx_valid(rx_valid), .rx_tag(rx_tag), .rx_crc_bad(rx_crc_bad), .rx_is_maint(rx_is_maint),
  .rx_ack_valid(rx_ack_valid), .rx_ack_kind(rx_ack_kind), .rx_ack_tag(rx_ack_tag), .rx_crc_redo(rx_crc_redo),
  .tx_ack_valid(tx_ack_valid), .tx_ack_kind(tx_ack_kind), .lresp_valid(lresp_valid), .tx_send(tx_send),
  .lreq_send(lreq_send), .out_err_stop(out_err_stop), .link_timeout(link_timeout));

// ===== tb/ppdr_partner.sv
// link partner model: acknowledges packets and answers link-requests
`timescale 1ns/1ps
module ppdr_partner (
  input  wire logic                clock,        // clock
  input  wire logic                rst,          // reset
  input  wire logic [1:0]          mode,         // 0 accept, 1 refuse once, 2 silent
  input  wire logic [3:0]          dly,          // answer delay
  input  wire logic                tx_send,      // packet sent
  input  wire ppdr_pkg::ppdr_tag_t tx_tag,       // its tag
  input  wire logic                lreq_send,    // link-request
  output logic                     tx_ack_valid, // ack pulse
  output ppdr_pkg::ppdr_ack_e      tx_ack_kind,  // ack kind
  output ppdr_pkg::ppdr_tag_t      tx_ack_tag,   // ack tag
  output logic                     lresp_valid,  // link-response
  output ppdr_pkg::ppdr_tag_t      lresp_tag     // next expected tag
);
  import ppdr_pkg::*;
  logic [4:0] ack_cnt_r, lr_cnt_r;
  logic       nacked_r;
  ppdr_tag_t  tag_r;
  always_ff @(posedge clock) begin
    tx_ack_valid <= 1'b0;
    lresp_valid  <= 1'b0;
    tx_ack_kind  <= PPDR_ACK_NONE;
    // idle tag lines toggle so a stale value never looks like an answer
    tx_ack_tag   <= ~tx_ack_tag;
    lresp_tag    <= ~lresp_tag;
    ack_cnt_r    <= (ack_cnt_r > 5'h01) ? ack_cnt_r - 5'h01 : 5'h00;
    lr_cnt_r     <= (lr_cnt_r > 5'h01) ? lr_cnt_r - 5'h01 : 5'h00;
    if (mode == 2'h0) nacked_r <= 1'b0;
    if (tx_send) begin
      tag_r <= tx_tag;
      if (mode != 2'h2) ack_cnt_r <= {1'b0, dly} + 5'h01;
    end
    if (ack_cnt_r == 5'h01) begin
      tx_ack_valid <= 1'b1;
      tx_ack_tag   <= tag_r;
      if (mode == 2'h1) nacked_r <= 1'b1;
      tx_ack_kind  <= (mode == 2'h1 && !nacked_r) ? PPDR_ACK_NOT_ACC : PPDR_ACK_ACCEPT;
    end
    if (lreq_send) lr_cnt_r <= {1'b0, dly} + 5'h01;
    if (lr_cnt_r == 5'h01) begin
      lresp_valid <= 1'b1;
      lresp_tag   <= tag_r;
    end
    if (rst) begin
      ack_cnt_r  <= 5'h00;
      lr_cnt_r   <= 5'h00;
      nacked_r   <= 1'b0;
      tx_ack_tag <= 6'h00;
      lresp_tag  <= 6'h00;
    end
  end
endmodule : ppdr_partner

// ===== tb/ppdr_port_tb.sv
// bench for the port priority, deadlock and retransmit block
`timescale 1ns/1ps
module ppdr_port_tb;
  import ppdr_pkg::*;
  logic        clock, rst, rx_valid, rx_crc_bad, rx_is_maint, in_release, fwd_ready, tq_valid, tq_is_resp;
  logic        tq_needs_resp, tq_two_resp, resp_rx, tx_ack_valid, lresp_valid, rx_ack_valid, rx_crc_redo;
  logic        fwd_valid, tq_ready, tx_send, lreq_send, out_err_stop, link_timeout, resp_timeout;
  logic [23:0] link_to_cfg, resp_to_cfg;
  logic [31:0] rx_data, fwd_data;
  logic [7:0]  retry_limit;
  logic [3:0]  dly;
  logic [1:0]  mode;
  ppdr_prio_t  rx_prio, in_rel_prio, tq_req_prio, tx_prio;
  ppdr_tag_t   rx_tag, rx_ack_tag, tx_ack_tag, lresp_tag, tx_tag, tg;
  ppdr_ack_e   rx_ack_kind, tx_ack_kind;
  int          n_errors = 0, n_tests = 0, cyc = 0, n;
  ppdr_port #(.IS_SWITCH(1'b1), .USE_PROMOTE(1'b0), .DW(32), .FIFO_DEPTH(16)) ppdr_port_inst (
    .clock(clock), .rst(rst), .link_to_cfg(link_to_cfg), .resp_to_cfg(resp_to_cfg), .retry_limit(retry_limit),
    .rx_valid(rx_valid), .rx_prio(rx_prio), .rx_tag(rx_tag), .rx_crc_bad(rx_crc_bad), .rx_is_maint(rx_is_maint),
    .rx_data(rx_data), .in_release(in_release), .in_rel_prio(in_rel_prio), .rx_ack_valid(rx_ack_valid),
    .rx_ack_kind(rx_ack_kind), .rx_ack_tag(rx_ack_tag), .rx_crc_redo(rx_crc_redo), .fwd_data(fwd_data),
    .fwd_valid(fwd_valid), .fwd_ready(fwd_ready), .tq_valid(tq_valid), .tq_is_resp(tq_is_resp),
    .tq_needs_resp(tq_needs_resp), .tq_two_resp(tq_two_resp), .tq_req_prio(tq_req_prio), .tq_ready(tq_ready),
    .resp_rx(resp_rx), .tx_ack_valid(tx_ack_valid), .tx_ack_kind(tx_ack_kind), .tx_ack_tag(tx_ack_tag),
    .lresp_valid(lresp_valid), .lresp_tag(lresp_tag), .tx_send(tx_send), .tx_slot(), .tx_prio(tx_prio),
    .tx_tag(tx_tag), .lreq_send(lreq_send), .out_err_stop(out_err_stop), .link_timeout(link_timeout),
    .resp_timeout(resp_timeout), .pkt_unrecov());
  ppdr_partner ppdr_partner_inst (.clock(clock), .rst(rst), .mode(mode), .dly(dly), .tx_send(tx_send),
    .tx_tag(tx_tag), .lreq_send(lreq_send), .tx_ack_valid(tx_ack_valid), .tx_ack_kind(tx_ack_kind),
    .tx_ack_tag(tx_ack_tag), .lresp_valid(lresp_valid), .lresp_tag(lresp_tag));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic wrap_up();
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // bounded wait; leaves the cycle count in n
  task automatic wt(ref logic s, input int lim);
    #1;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(negedge clock);
      #1;
      n++;
    end
  endtask : wt
  task automatic rx_pkt(input ppdr_prio_t p, input ppdr_tag_t t, input logic bad, mnt, input ppdr_ack_e k);
    @(negedge clock);
    {rx_valid, rx_prio, rx_tag, rx_crc_bad, rx_is_maint} = {1'b1, p, t, bad, mnt};
    rx_data = 32'(t) + 32'h00005A00;
    @(negedge clock);
    rx_valid = 1'b0;
    chk("rx_ack_valid", 32'(k != PPDR_ACK_NONE), 32'(rx_ack_valid));
    if (k != PPDR_ACK_NONE) chk("rx_ack_kind", 32'(k), 32'(rx_ack_kind));
    if (k != PPDR_ACK_NONE) chk("rx_ack_tag", 32'(t), 32'(rx_ack_tag));
    chk("rx_crc_redo", 32'(mnt), 32'(rx_crc_redo));
  endtask : rx_pkt
  task automatic tx_pkt(input logic rsp, nr, two, input ppdr_prio_t p, ep, input logic wack);
    @(negedge clock);
    {tq_valid, tq_is_resp, tq_needs_resp, tq_two_resp, tq_req_prio} = {1'b1, rsp, nr, two, p};
    wt(tq_ready, 50);
    @(negedge clock);
    tq_valid = 1'b0;
    wt(tx_send, 50);
    tg = tx_tag;
    chk("tx_prio", 32'(ep), 32'(tx_prio));
    if (wack) wt(tx_ack_valid, 50);
  endtask : tx_pkt
  task automatic t_inbound();
    rx_pkt(2'h0, 6'h00, 1'b0, 1'b0, PPDR_ACK_ACCEPT);
    rx_pkt(2'h0, 6'h01, 1'b0, 1'b0, PPDR_ACK_RETRY);
    rx_pkt(2'h3, 6'h01, 1'b0, 1'b1, PPDR_ACK_ACCEPT);
    chk("fwd_data", 32'h00005A00, fwd_data);
    chk("fwd_valid", 32'h00000001, 32'(fwd_valid));
    @(negedge clock);
    {in_release, in_rel_prio} = 3'h4;
    @(negedge clock);
    in_release = 1'b0;
    rx_pkt(2'h0, 6'h02, 1'b0, 1'b0, PPDR_ACK_ACCEPT);
    fwd_ready = 1'b1;
  endtask : t_inbound
  task automatic t_resp();
    for (int k = 1; k <= 2; k++) begin
      tx_pkt(1'b0, 1'b1, 1'b1, 2'h1, 2'h1, 1'b1);
      repeat (k) begin
        @(negedge clock);
        resp_rx = 1'b1;
        @(negedge clock);
        resp_rx = 1'b0;
      end
      wt(resp_timeout, 400);
      chk("resp_timeout", 32'(k == 1), 32'(resp_timeout));
    end
  endtask : t_resp
  task automatic t_prio();
    tx_pkt(1'b0, 1'b1, 1'b0, 2'h3, 2'h2, 1'b1);
    dly = 4'h9;
    tx_pkt(1'b1, 1'b0, 1'b0, 2'h1, 2'h2, 1'b1);
    tx_pkt(1'b1, 1'b0, 1'b0, 2'h3, 2'h3, 1'b1);
    dly = 4'h0;
  endtask : t_prio
  task automatic t_nack();
    mode = 2'h1;
    tx_pkt(1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b1);
    wt(lreq_send, 20);
    chk("lreq_send", 32'h00000001, 32'(lreq_send));
    chk("out_err_stop", 32'h00000001, 32'(out_err_stop));
    wt(tx_send, 60);
    chk("tx_tag", 32'(tg), 32'(tx_tag));
    chk("out_err_stop", 32'h00000000, 32'(out_err_stop));
    wt(tx_ack_valid, 50);
    mode = 2'h0;
  endtask : t_nack
  task automatic t_linkto();
    mode = 2'h2;
    tx_pkt(1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0);
    rx_pkt(2'h1, 6'h03, 1'b0, 1'b0, PPDR_ACK_ACCEPT);
    wt(link_timeout, 100);
    chk("link_to_window", 32'h00000001, 32'(n >= 30 && n <= 45));
    mode = 2'h0;
    wt(lreq_send, 10);
    chk("lreq_send", 32'h00000001, 32'(lreq_send));
    wt(tx_send, 60);
    chk("tx_tag", 32'(tg), 32'(tx_tag));
    wt(tx_ack_valid, 50);
  endtask : t_linkto
  task automatic t_bad();
    rx_pkt(2'h1, 6'h04, 1'b1, 1'b0, PPDR_ACK_NOT_ACC);
    rx_pkt(2'h1, 6'h04, 1'b0, 1'b0, PPDR_ACK_NONE);
  endtask : t_bad
  initial begin
    {rst, rx_valid, rx_crc_bad, rx_is_maint, in_release, fwd_ready, tq_valid, tq_is_resp} = 8'h80;
    {tq_needs_resp, tq_two_resp, resp_rx, rx_prio, in_rel_prio, tq_req_prio, rx_tag, rx_data, mode, dly} = '0;
    {link_to_cfg, resp_to_cfg, retry_limit} = {24'h000028, 24'h0000C8, 8'h02};
    repeat (3) @(negedge clock);
    rst = 1'b0;
    t_inbound();
    t_resp();
    t_prio();
    t_nack();
    t_linkto();
    t_bad();
    wrap_up();
  end
endmodule : ppdr_port_tb
